// ---- rtl/bridge_error_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module bridge_error_capture #(
   parameter bit INV_PRESENT = 1'b1            // Later revision has INV
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     reset_i,
   input  wire logic [11:0]              err_event_i,
   input  wire irq_err_pkg::err_info_t   err_info_i,
   input  wire logic                     clear_wr_i,
   input  wire logic [11:0]              clear_bits_i,
   output logic      [63:0]              err_reg_o,
   output logic                          frozen_o,
   output logic                          capture_o,
   output logic                          lost_o
);

   // ==========================================================
   // State
   logic [11:0] bits_q,  bits_d;                // Error flags
   logic [7:0]  synd_q;                         // Captured syndrome
   logic [3:0]  cmd_q;                          // Captured command
   logic [34:0] addr_q;                         // Captured address
   logic        inv_q;                          // Info not valid

   // ==========================================================
   // Decode
   wire logic [11:0] ev       = err_event_i & irq_err_pkg::ERR_EVENT_MASK;
   wire logic        any_ev   = |ev;
   wire logic        frozen   = |bits_q;
   wire logic        capture  = any_ev & ~frozen;
   // Frozen or mid-clear: the new error is only counted as lost
   wire logic        lost_set = any_ev & frozen;
   wire logic [11:0] clr      = clear_wr_i ?
                       (clear_bits_i & irq_err_pkg::ERR_CLEAR_MASK) : 12'h000;
   wire logic        is_ecc   = ev[irq_err_pkg::CORR_ECC_BIT] |
                                ev[irq_err_pkg::UNCORR_ECC_BIT];

   // Set beats clear so that an error in the clear cycle survives
   assign bits_d = (bits_q & ~clr) | (capture ? ev : 12'h000) |
                   {11'h000, lost_set};

   // ==========================================================
   // Flag register
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         bits_q <= irq_err_pkg::RESET_WORD[11:0];
      end else begin
         bits_q <= bits_d;
      end
   end

   // ==========================================================
   // Information capture; held while frozen
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         synd_q <= 8'h00;
         cmd_q  <= 4'h0;
         addr_q <= 35'h000000000;
         inv_q  <= 1'b0;
      end else if (capture) begin
         // Syndrome only means something for ECC errors
         synd_q <= is_ecc ? err_info_i.syndrome : 8'h00;
         cmd_q  <= err_info_i.command;
         // ECC errors report a quadword address
         addr_q <= is_ecc ? {err_info_i.address[34:3], 3'h0}
                          : err_info_i.address;
         // Older revision reads this bit as zero
         inv_q  <= INV_PRESENT & ~err_info_i.info_valid;
      end
   end

   // Reserved bits 15:12 read as zero
   assign err_reg_o = {synd_q, cmd_q, inv_q, addr_q, 4'h0, bits_q};
   assign frozen_o  = frozen;
   assign capture_o = capture;
   assign lost_o    = lost_set;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   chk_frozen_info_hold: assert property (frozen |=> $stable(err_reg_o[63:16]))
      else $error("captured info changed while frozen");
   chk_lost_on_frozen: assert property (lost_set |=> err_reg_o[0])
      else $error("lost flag not set after frozen error");
   chk_capture_flags: assert property (capture |=>
         ((err_reg_o[11:0] & $past(ev)) == $past(ev)) && frozen_o)
      else $error("capture did not set its flags and freeze");
   chk_capture_inv: assert property (capture |=>
         err_reg_o[51] == (INV_PRESENT & !$past(err_info_i.info_valid)))
      else $error("info not valid bit wrong after capture");
   chk_syndrome_non_ecc: assert property (capture && !is_ecc |=>
         err_reg_o[63:56] == 8'h00)
      else $error("syndrome kept for non ecc error");

   cov_lost_error: cover property (lost_set ##1 clear_wr_i);

endmodule : bridge_error_capture

`default_nettype wire

// ---- rtl/irq_err_pkg.sv ----
package irq_err_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 44;                  // Byte address width
   localparam int DATA_W = 64;                  // Register width
   localparam int NUM_CPU = 2;                  // Processors served

   // ==========================================================
   // Register byte addresses
   localparam logic [43:0] REQ0_OFFSET   = 44'h801a0000280;
   localparam logic [43:0] REQ1_OFFSET   = 44'h801a00002c0;
   localparam logic [43:0] MISC_OFFSET   = 44'h801a0000080;
   localparam logic [43:0] BERR_OFFSET   = 44'h801a0000100;
   localparam logic [43:0] ISTAT_OFFSET  = 44'h801a0000140;
   localparam logic [43:0] ICLR_OFFSET   = 44'h801a0000180;
   localparam logic [43:0] IEN_OFFSET    = 44'h801a00001c0;

   // ==========================================================
   // Shared register fields
   localparam int CPU_LSB   = 0;                // Reader number, 2 bits
   localparam int CPU_W     = 2;
   localparam int TIMER_LSB = 4;                // Timer pending, 4 bits
   localparam int TIMER_W   = 4;
   localparam int NXM_BIT   = 28;               // Nonexistent memory flag
   localparam int SRC_LSB   = 29;               // Source, 3 bits
   localparam int SRC_W     = 3;

   // ==========================================================
   // Device interrupt request fields
   localparam int DIR_NXM_BIT  = 63;
   localparam int DIR_BERR_BIT = 62;
   localparam int PCI_IRQ_W    = 56;            // Bits 55:0

   // ==========================================================
   // Bridge error register fields
   localparam int SYND_LSB   = 56;              // Syndrome, 8 bits
   localparam int CMD_LSB    = 52;              // Command, 4 bits
   localparam int INV_BIT    = 51;              // Info not valid
   localparam int ADDR_LSB   = 16;              // Address, 35 bits
   localparam int ERR_BITS_W = 12;              // Error flags 11:0
   localparam int LOST_BIT   = 0;
   localparam int CORR_ECC_BIT   = 11;          // Correctable ECC
   localparam int UNCORR_ECC_BIT = 10;          // Uncorrectable ECC
   // Flags that hardware may set on capture; bit 9 is reserved
   localparam logic [11:0] ERR_EVENT_MASK = 12'hdfe;
   localparam logic [11:0] ERR_CLEAR_MASK = 12'hdff;

   // ECC access kinds carried in the command field
   localparam logic [3:0] CMD_DMA_READ = 4'h0;
   localparam logic [3:0] CMD_DMA_RMW  = 4'h1;
   localparam logic [3:0] CMD_SG_READ  = 4'h3;

   // ==========================================================
   // Interrupt status bit positions
   localparam int EV_TIMER = 0;
   localparam int EV_NXM   = 1;
   localparam int EV_BERR  = 2;
   localparam int EV_LOST  = 3;
   localparam int EV_W     = 4;

   // Reset values
   localparam logic [63:0] RESET_WORD = 64'h0;
   localparam logic [3:0]  RESET_EV   = 4'h0;

   // Error information offered by the bridge with each event
   typedef struct packed {
      logic [7:0]  syndrome;
      logic [3:0]  command;
      logic [34:0] address;
      logic        info_valid;
   } err_info_t;

endpackage : irq_err_pkg

// ---- rtl/irq_err_report.sv ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Timer pending bits 7:4, write one clears
// - Bits 1:0 return the reading CPU number
// - Two read-only request registers, one per CPU
// - Bit 63 nonexistent memory, bit 62 bridge error
// - Bits 55:0 PCI pending, 61:56 read zero
// - Any error flag set freezes bridge register
// - While frozen only bit 0 may newly set
// - Capture info into 63:16 when error sets
// - Set info-not-valid on capture when info invalid; software honours it
// - Info-not-valid meaningful with flags; older revision zero
// - Syndrome held for correctable or uncorrectable ECC
// - Command field; ECC access kind encodings
// - Lost bit sets on error after freeze
// - Nonexistent memory flag drives bit 63, locks source
module irq_err_report #(
   parameter bit INV_PRESENT = 1'b1             // Later revision has INV
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     reset_i,
   input  wire logic [43:0]              reg_addr_i,
   input  wire logic [63:0]              reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   input  wire logic [1:0]               reg_cpu_i,
   output logic      [63:0]              reg_rdata_o,
   input  wire logic [3:0]               timer_tick_i,
   input  wire logic                     nxm_detect_i,
   input  wire logic [2:0]               nxm_source_i,
   input  wire logic [11:0]              err_event_i,
   input  wire irq_err_pkg::err_info_t   err_info_i,
   input  wire logic                     bridge1_error_i,
   input  wire logic [55:0]              pci_irq_cpu0_i,
   input  wire logic [55:0]              pci_irq_cpu1_i,
   output logic      [3:0]               timer_irq_pending_o,
   output logic      [1:0]               error_interrupt_line_o,
   output logic      [1:0]               pci_interrupt_line_o,
   output logic                          irq_o
);

   // ==========================================================
   // Address decode
   wire logic hit_misc = reg_addr_i == irq_err_pkg::MISC_OFFSET;
   wire logic hit_req0 = reg_addr_i == irq_err_pkg::REQ0_OFFSET;
   wire logic hit_req1 = reg_addr_i == irq_err_pkg::REQ1_OFFSET;
   wire logic hit_berr = reg_addr_i == irq_err_pkg::BERR_OFFSET;
   wire logic hit_stat = reg_addr_i == irq_err_pkg::ISTAT_OFFSET;
   wire logic hit_clr  = reg_addr_i == irq_err_pkg::ICLR_OFFSET;
   wire logic hit_en   = reg_addr_i == irq_err_pkg::IEN_OFFSET;

   // Write strobes per register; the request and status registers take none
   wire logic wr_misc = reg_wr_i & hit_misc;
   wire logic wr_berr = reg_wr_i & hit_berr;
   wire logic wr_clr  = reg_wr_i & hit_clr;
   wire logic wr_en   = reg_wr_i & hit_en;

   // ==========================================================
   // Shared register state
   logic [3:0] timer_q, timer_d;                // Interval timer pending
   logic       nxm_q,   nxm_d;                  // Nonexistent memory
   logic [2:0] src_q,   src_d;                  // Source of that access

   wire logic [3:0] timer_clr = wr_misc ?
        reg_wdata_i[irq_err_pkg::TIMER_LSB +: irq_err_pkg::TIMER_W] : 4'h0;
   wire logic       nxm_clr   = wr_misc & reg_wdata_i[irq_err_pkg::NXM_BIT];

   // Set beats clear: a tick in the clearing cycle is not lost
   assign timer_d = (timer_q & ~timer_clr) | timer_tick_i;
   assign nxm_d   = nxm_detect_i | (nxm_q & ~nxm_clr);
   // Source is frozen for as long as the flag stands
   assign src_d   = (!nxm_q && nxm_detect_i) ? nxm_source_i : src_q;

   // ==========================================================
   // Shared register flops
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         timer_q <= irq_err_pkg::RESET_EV;
         nxm_q   <= 1'b0;
         src_q   <= 3'h0;
      end else begin
         timer_q <= timer_d;
         nxm_q   <= nxm_d;
         src_q   <= src_d;
      end
   end

   // Timer lines follow the pending bits directly
   assign timer_irq_pending_o = timer_q;

   // ==========================================================
   // Bridge error register
   logic [63:0] berr_word;                      // Read view
   logic        berr_frozen;                    // Any flag set
   logic        berr_capture;                   // New error taken
   logic        berr_lost;                      // Error dropped

   bridge_error_capture #(
      .INV_PRESENT (INV_PRESENT)
   ) u_capture (
      .clk_sys_i    (clk_sys_i),
      .reset_i      (reset_i),
      .err_event_i  (err_event_i),
      .err_info_i   (err_info_i),
      .clear_wr_i   (wr_berr),
      .clear_bits_i (reg_wdata_i[11:0]),
      .err_reg_o    (berr_word),
      .frozen_o     (berr_frozen),
      .capture_o    (berr_capture),
      .lost_o       (berr_lost)
   );

   // Second bridge error arrives on a pin: two flops first
   logic b1_meta_q;
   logic b1_sync_q;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         b1_meta_q <= 1'b0;
         b1_sync_q <= 1'b0;
      end else begin
         b1_meta_q <= bridge1_error_i;
         b1_sync_q <= b1_meta_q;
      end
   end

   // Either bridge raises the shared error bit
   wire logic bridge_err = berr_frozen | b1_sync_q;

   // ==========================================================
   // Per-CPU request registers and interrupt lines
   logic [55:0] pci_pin   [irq_err_pkg::NUM_CPU];
   logic [63:0] dir_word  [irq_err_pkg::NUM_CPU];
   logic [1:0]  err_line_q;                     // Error line flops
   logic [1:0]  pci_line_q;                     // PCI line flops

   assign pci_pin[0] = pci_irq_cpu0_i;
   assign pci_pin[1] = pci_irq_cpu1_i;

   for (genvar g = 0; g < irq_err_pkg::NUM_CPU; g++) begin : g_cpu
      logic [55:0] meta_q;                      // First sync stage
      logic [55:0] sync_q;                      // Second sync stage

      // Pending lines come from outside: resynchronise
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            meta_q <= 56'h0;
            sync_q <= 56'h0;
         end else begin
            meta_q <= pci_pin[g];
            sync_q <= meta_q;
         end
      end

      // Reserved 61:56 read as zero
      assign dir_word[g] = {nxm_q, bridge_err, 6'h00, sync_q};

      // Lines lag the bits by one cycle so outputs come from flops
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            err_line_q[g] <= 1'b0;
            pci_line_q[g] <= 1'b0;
         end else begin
            err_line_q[g] <= nxm_q | bridge_err;
            pci_line_q[g] <= |sync_q;
         end
      end
   end

   assign error_interrupt_line_o = err_line_q;
   assign pci_interrupt_line_o   = pci_line_q;

   // ==========================================================
   // Block interrupt: sticky status, enable, write-one clear
   logic [3:0] stat_q, stat_d;                  // Sticky events
   logic [3:0] en_q;                            // Enables
   logic       irq_q;                           // Level output

   wire logic [3:0] ev_now = {berr_lost, berr_capture,
                              nxm_detect_i & ~nxm_q, |timer_tick_i};
   wire logic [3:0] ev_clr = wr_clr ? reg_wdata_i[3:0] : 4'h0;

   // An event in the clearing cycle keeps its bit
   assign stat_d = ev_now | (stat_q & ~ev_clr);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         stat_q <= irq_err_pkg::RESET_EV;
         en_q   <= irq_err_pkg::RESET_EV;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr_en) begin
            en_q <= reg_wdata_i[3:0];
         end
         irq_q  <= |(stat_q & en_q);
      end
   end

   assign irq_o = irq_q;

   // ==========================================================
   // Read path
   // Unused shared fields read as zero; CPU number is the reader's
   wire logic [63:0] misc_word = {32'h0, src_q, nxm_q, 20'h00000,
                                  timer_q, 2'b00, reg_cpu_i};
   wire logic [63:0] rd_word =
        hit_misc ? misc_word :
        hit_req0 ? dir_word[0] :
        hit_req1 ? dir_word[1] :
        hit_berr ? berr_word :
        hit_stat ? {60'h0, stat_q} :
        hit_en   ? {60'h0, en_q} :
                   irq_err_pkg::RESET_WORD;     // Unmapped or clear

   logic [63:0] rdata_q;                        // Data the cycle after

   // Data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_q <= irq_err_pkg::RESET_WORD;
      end else begin
         rdata_q <= reg_rd_i ? rd_word : irq_err_pkg::RESET_WORD;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   chk_timer_tick_sets: assert property ((|timer_tick_i) |=>
         ((timer_irq_pending_o & $past(timer_tick_i)) == $past(timer_tick_i)))
      else $error("timer tick did not set pending bit");
   chk_timer_w1c: assert property (wr_misc && reg_wdata_i[4] &&
         !timer_tick_i[0] |=> !timer_irq_pending_o[0])
      else $error("timer pending bit not cleared by write");
   chk_cpu_readback: assert property (reg_rd_i && hit_misc |=>
         reg_rdata_o[1:0] == $past(reg_cpu_i))
      else $error("reader number not returned");
   chk_dir_layout: assert property (reg_rd_i && hit_req1 |=>
         reg_rdata_o[63] == $past(nxm_q) && reg_rdata_o[61:56] == 6'h00)
      else $error("request register layout wrong");
   chk_source_lock: assert property (nxm_q |=> src_q == $past(src_q))
      else $error("source field moved while flag set");
   // Line flop lags the flag by one edge; a clear may follow at once
   chk_error_line: assert property (nxm_q |-> ##1 error_interrupt_line_o[0])
      else $error("error line not raised by nonexistent memory");
   chk_irq_level: assert property ((|(stat_q & en_q)) && !wr_clr && !wr_en
         |=> irq_o)
      else $error("interrupt output low with enabled status");

   cov_nxm_read: cover property (nxm_q && reg_rd_i && hit_req0);
   cov_berr_read: cover property (berr_capture ##[1:8] (reg_rd_i && hit_berr));
   cov_irq_rise: cover property ($rose(irq_o));

endmodule : irq_err_report

`default_nettype wire

// ---- verification/error_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bridge error source: one-cycle event with its information
module error_source_model (
   input  wire logic                   clk_sys_i,
   input  wire logic                   fire_i,
   input  wire logic [11:0]            flags_i,
   input  wire irq_err_pkg::err_info_t info_i,
   output var  logic [11:0]            err_event_o,
   output var  irq_err_pkg::err_info_t err_info_o
);
   // Info outside the event cycle is inverted, so a capture that
   // samples late sees garbage rather than a lucky stale value
   always_ff @(posedge clk_sys_i) begin
      err_event_o <= fire_i ? flags_i : 12'h000;
      err_info_o  <= fire_i ? info_i : ~info_i;
   end
endmodule : error_source_model

`default_nettype wire

// ---- verification/test_irq_err_report.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_irq_err_report;
   // ==========================================================
   // Stimulus and observed signals
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [43:0] reg_addr_i = 44'h0;
   logic [63:0] reg_wdata_i = 64'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [1:0]  reg_cpu_i = 2'h0;
   logic [3:0]  timer_tick_i = 4'h0;
   logic        nxm_detect_i = 1'b0;
   logic [2:0]  nxm_source_i = 3'h0;
   logic        bridge1_error_i = 1'b0;
   logic [55:0] pci_irq_cpu0_i = 56'h0;
   logic [55:0] pci_irq_cpu1_i = 56'h0;
   logic        fire = 1'b0;                // Request to the source model
   logic [11:0] fire_flags = 12'h0;
   irq_err_pkg::err_info_t fire_info = '0;
   logic [63:0] reg_rdata_o;
   logic [11:0] err_event_i;
   irq_err_pkg::err_info_t err_info_i;
   logic [3:0]  timer_irq_pending_o;
   logic [1:0]  error_interrupt_line_o;
   logic [1:0]  pci_interrupt_line_o;
   logic        irq_o;
   logic [63:0] rd_word;                    // Last read answer
   int          failures = 0;
   int          tests_run = 0;

   always #20 clk_sys_i = ~clk_sys_i;       // 25 MHz

   irq_err_report i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_cpu_i(reg_cpu_i),
      .reg_rdata_o(reg_rdata_o), .timer_tick_i(timer_tick_i),
      .nxm_detect_i(nxm_detect_i), .nxm_source_i(nxm_source_i),
      .err_event_i(err_event_i), .err_info_i(err_info_i),
      .bridge1_error_i(bridge1_error_i), .pci_irq_cpu0_i(pci_irq_cpu0_i),
      .pci_irq_cpu1_i(pci_irq_cpu1_i),
      .timer_irq_pending_o(timer_irq_pending_o),
      .error_interrupt_line_o(error_interrupt_line_o),
      .pci_interrupt_line_o(pci_interrupt_line_o), .irq_o(irq_o));

   error_source_model i_src (.clk_sys_i(clk_sys_i), .fire_i(fire),
      .flags_i(fire_flags), .info_i(fire_info),
      .err_event_o(err_event_i), .err_info_o(err_info_i));

   // ==========================================================
   // Bus, event and compare tasks
   task automatic bus_wr(input logic [43:0] a, input logic [63:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask : bus_wr

   // Answer stands only in the cycle after the strobe
   task automatic bus_rd(input logic [43:0] a, input logic [1:0] c);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_cpu_i  <= c;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1 rd_word = reg_rdata_o;
   endtask : bus_rd

   task automatic bridge_event(input logic [11:0] f,
                               input irq_err_pkg::err_info_t i);
      @(posedge clk_sys_i);
      fire       <= 1'b1;
      fire_flags <= f;
      fire_info  <= i;
      @(posedge clk_sys_i);
      fire       <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
   endtask : bridge_event

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // Expectation helpers
   // ECC captures keep a quadword address and the syndrome
   function automatic logic [63:0] exp_berr(input logic [11:0] f,
      input irq_err_pkg::err_info_t i, input logic ecc);
      logic [34:0] a;
      a = ecc ? {i.address[34:3], 3'b000} : i.address;
      return {(ecc ? i.syndrome : 8'h00), i.command, ~i.info_valid, a,
              4'h0, f};
   endfunction : exp_berr

   function automatic irq_err_pkg::err_info_t rnd_info(input logic v,
                                                       input logic [3:0] c);
      irq_err_pkg::err_info_t r;
      r.syndrome   = 8'($urandom);
      r.command    = c;
      r.address    = {3'($urandom), 32'($urandom)};
      r.info_valid = v;
      return r;
   endfunction : rnd_info

   // ==========================================================
   // Main sequence
   initial begin : main
      logic [43:0]            map [5];
      logic [3:0]             cmds [3];
      logic [3:0]             t;
      logic [11:0]            f;
      irq_err_pkg::err_info_t inf;
      int                     seed;
      map  = '{irq_err_pkg::REQ0_OFFSET, irq_err_pkg::REQ1_OFFSET,
               irq_err_pkg::BERR_OFFSET, irq_err_pkg::ISTAT_OFFSET,
               44'h801a0000300};
      cmds = '{irq_err_pkg::CMD_DMA_READ, irq_err_pkg::CMD_DMA_RMW,
               irq_err_pkg::CMD_SG_READ};
      seed = $urandom(32'hee41);
      repeat (5) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      // Reset contents, an unmapped place among them
      foreach (map[k]) begin
         bus_rd(map[k], 2'(k));
         chk(rd_word, 64'h0);
      end
      for (int c = 0; c < 4; c++) begin
         bus_rd(irq_err_pkg::MISC_OFFSET, 2'(c));
         chk(rd_word, 64'(c));
      end
      // Timer pending bits, then partial write-one clear
      t = 4'($urandom) | 4'h1;
      @(posedge clk_sys_i);
      timer_tick_i <= t;
      @(posedge clk_sys_i);
      timer_tick_i <= 4'h0;
      repeat (2) @(posedge clk_sys_i);
      chk(64'(timer_irq_pending_o), 64'(t));
      bus_wr(irq_err_pkg::MISC_OFFSET, 64'h50);
      bus_rd(irq_err_pkg::MISC_OFFSET, 2'h0);
      t = t & 4'ha;
      chk(rd_word, {56'h0, t, 4'h0});
      // PCI pending bits cross the synchroniser; writes are ignored
      @(posedge clk_sys_i);
      pci_irq_cpu0_i <= {24'($urandom), 32'($urandom)} | 56'h1;
      pci_irq_cpu1_i <= {24'($urandom), 32'($urandom)} | 56'h1;
      bus_wr(irq_err_pkg::REQ0_OFFSET, '1);
      bus_rd(irq_err_pkg::REQ0_OFFSET, 2'h0);
      chk(rd_word, {8'h0, pci_irq_cpu0_i});
      bus_rd(irq_err_pkg::REQ1_OFFSET, 2'h1);
      chk(rd_word, {8'h0, pci_irq_cpu1_i});
      chk(64'(pci_interrupt_line_o), 64'h3);
      // Nonexistent memory: source locked by the first report
      for (int n = 0; n < 2; n++) begin
         @(posedge clk_sys_i);
         nxm_detect_i <= 1'b1;
         nxm_source_i <= (n == 0) ? 3'h5 : 3'h2;
         @(posedge clk_sys_i);
         nxm_detect_i <= 1'b0;
         bus_rd(irq_err_pkg::MISC_OFFSET, 2'h1);
         chk(rd_word, {32'h0, 4'hb, 20'h0, t, 4'h1});
      end
      bus_rd(irq_err_pkg::REQ1_OFFSET, 2'h1);
      chk(rd_word, {2'b10, 6'h0, pci_irq_cpu1_i});
      chk(64'(error_interrupt_line_o), 64'h3);
      // Status, enable, level interrupt, clear
      bus_wr(irq_err_pkg::IEN_OFFSET, 64'h2);
      bus_wr(irq_err_pkg::MISC_OFFSET, 64'h1000_0000);
      repeat (2) @(posedge clk_sys_i);
      chk(64'(irq_o), 64'h1);
      bus_wr(irq_err_pkg::ICLR_OFFSET, 64'h2);
      repeat (2) @(posedge clk_sys_i);
      chk(64'(irq_o), 64'h0);
      bus_rd(irq_err_pkg::ISTAT_OFFSET, 2'h0);
      chk(rd_word, 64'h1);
      // ECC captures for every access kind, then a lost error
      foreach (cmds[k]) begin
         inf = rnd_info(1'b1, cmds[k]);
         f = (k == 1) ? 12'h400 : 12'h800;
         bridge_event(f, inf);
         bus_rd(irq_err_pkg::BERR_OFFSET, 2'h0);
         chk(rd_word, exp_berr(f, inf, 1'b1));
         bridge_event(12'h0a0, rnd_info(1'b1, 4'h7));
         bus_rd(irq_err_pkg::BERR_OFFSET, 2'h0);
         chk(rd_word, exp_berr(f | 12'h1, inf, 1'b1));
         bus_rd(irq_err_pkg::REQ0_OFFSET, 2'h0);
         chk(rd_word, {2'b01, 6'h0, pci_irq_cpu0_i});
         bus_wr(irq_err_pkg::BERR_OFFSET, 64'hdff);
         bus_rd(irq_err_pkg::BERR_OFFSET, 2'h0);
         chk(64'(rd_word[11:0]), 64'h0);
      end
      bus_rd(irq_err_pkg::ISTAT_OFFSET, 2'h0);
      chk(rd_word, 64'hd);
      // Non-ECC capture with invalid information after unfreeze
      bus_wr(irq_err_pkg::IEN_OFFSET, 64'h4);
      bus_wr(irq_err_pkg::ICLR_OFFSET, 64'hf);
      inf = rnd_info(1'b0, 4'($urandom));
      bridge_event(12'h004, inf);
      bus_rd(irq_err_pkg::BERR_OFFSET, 2'h0);
      chk(rd_word, exp_berr(12'h004, inf, 1'b0));
      chk(64'(irq_o), 64'h1);
      bus_wr(irq_err_pkg::BERR_OFFSET, 64'hdff);
      bridge1_error_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      bus_rd(irq_err_pkg::REQ1_OFFSET, 2'h1);
      chk(rd_word, {2'b01, 6'h0, pci_irq_cpu1_i});
      print_verdict();
   end : main

   // Cuts a hang short well inside the cycle budget
   initial begin : watchdog
      #(40 * 20000);
      failures++;
      print_verdict();
   end : watchdog
endmodule : test_irq_err_report

`default_nettype wire
